// ---- logic/shrp_consts.svh ----
// Constants for the serial host register port
`ifndef SHRP_CONSTS_SVH
`define SHRP_CONSTS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SHRP_INSTR_BITS 5
`define SHRP_ADDR_BITS 11
`define SHRP_DATA_BITS 8
`define SHRP_HDR_BITS 16
`define SHRP_HDR_LAST 5'h0F
`define SHRP_DATA_LAST 5'h07
`define SHRP_DIR_POS 15
`define SHRP_DIR_READ 1'b1

// ----------------------------------------------------------------
// Pin synchroniser
// ----------------------------------------------------------------
`define SHRP_SYNC_STAGES 3
`define SHRP_PIN_SEL 2
`define SHRP_PIN_SCLK 1
`define SHRP_PIN_SDI 0
`define SHRP_PIN_RESET 3'h4

`endif

// ---- logic/shrp_pkg.sv ----
// Types shared by the serial host register port
`include "shrp_consts.svh"

package shrp_pkg;

    // Register access request handed to the register file
    typedef struct packed {
        logic wr;
        logic [`SHRP_INSTR_BITS-2:0] instr_low;
        logic [`SHRP_ADDR_BITS-1:0] addr;
        logic [`SHRP_DATA_BITS-1:0] data;
    } shrp_req_t;

    typedef enum logic [4:0] {
        SHRP_IDLE  = 5'h01,
        SHRP_HDR   = 5'h02,
        SHRP_WDATA = 5'h04,
        SHRP_RDATA = 5'h08,
        SHRP_DONE  = 5'h10
    } shrp_state_t;

endpackage

// ---- logic/shrp_serial_port.sv ----
// Serial host port giving an external processor access to the internal registers
`timescale 1ns/100ps
`default_nettype none
`include "shrp_consts.svh"

// Summary of operation
// - Select falling starts one access; select rising ends it.
// - After select low, five instruction bits are sampled on serial clock rising edges.
// - Instruction MSB one means read, zero means write.
// - An eleven-bit register address follows the instruction directly.
// - Read data leaves on the serial output, changing on serial clock falling edges.
// - Write data follows the address and is stored in the addressed register.
module shrp_serial_port
    import shrp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic host_sel_n,
    input wire logic host_sclk,
    input wire logic host_serial_in,
    output logic host_serial_out,
    output logic host_serial_out_oe_n,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output shrp_req_t reg_req,
    input wire logic [`SHRP_DATA_BITS-1:0] reg_rd_data
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // A change counts only once stages two and three agree, which
    // rejects a single-cycle glitch on the slow host pins.
    logic [2:0] pins_in;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] flt_r;
    logic [2:0] flt_prev_r;

    assign pins_in = {host_sel_n, host_sclk, host_serial_in};

    localparam logic [2:0] pin_rst_val = `SHRP_PIN_RESET;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    sync1_r[gi] <= pin_rst_val[gi];
                    sync2_r[gi] <= pin_rst_val[gi];
                    sync3_r[gi] <= pin_rst_val[gi];
                    flt_r[gi] <= pin_rst_val[gi];
                    flt_prev_r[gi] <= pin_rst_val[gi];
                end
                else
                begin
                    sync1_r[gi] <= pins_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi])
                    begin
                        flt_r[gi] <= sync3_r[gi];
                    end
                    flt_prev_r[gi] <= flt_r[gi];
                end
            end
        end
    endgenerate

    logic sel_n_f;
    logic sel_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic sdi_f;

    assign sel_n_f = flt_r[`SHRP_PIN_SEL];
    assign sel_fall = flt_prev_r[`SHRP_PIN_SEL] & ~flt_r[`SHRP_PIN_SEL];
    assign sclk_rise = flt_r[`SHRP_PIN_SCLK] & ~flt_prev_r[`SHRP_PIN_SCLK];
    assign sclk_fall = flt_prev_r[`SHRP_PIN_SCLK] & ~flt_r[`SHRP_PIN_SCLK];
    assign sdi_f = flt_r[`SHRP_PIN_SDI];

    // Next filtered select, so the output clears in the cycle the enable releases
    logic sel_n_nxt;

    assign sel_n_nxt = (sync2_r[`SHRP_PIN_SEL] == sync3_r[`SHRP_PIN_SEL])
        ? sync3_r[`SHRP_PIN_SEL] : flt_r[`SHRP_PIN_SEL];

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    shrp_state_t state_r;
    logic [4:0] cnt_r;
    logic [`SHRP_HDR_BITS-1:0] hdr_r;
    logic [`SHRP_DATA_BITS-1:0] wdata_r;
    logic [`SHRP_HDR_BITS-1:0] hdr_nxt;
    logic [`SHRP_DATA_BITS-1:0] wdata_nxt;

    assign hdr_nxt = {hdr_r[`SHRP_HDR_BITS-2:0], sdi_f};
    assign wdata_nxt = {wdata_r[`SHRP_DATA_BITS-2:0], sdi_f};

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= SHRP_IDLE;
            cnt_r <= 5'h00;
            hdr_r <= 16'h0000;
            wdata_r <= 8'h00;
        end
        else if (sel_n_f)
        begin
            // Select high abandons any partial frame
            state_r <= SHRP_IDLE;
            cnt_r <= 5'h00;
        end
        else
        begin
            unique case (state_r)
                SHRP_IDLE:
                begin
                    if (sel_fall)
                    begin
                        state_r <= SHRP_HDR;
                        cnt_r <= 5'h00;
                    end
                end
                SHRP_HDR:
                begin
                    if (sclk_rise)
                    begin
                        hdr_r <= hdr_nxt;
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == `SHRP_HDR_LAST)
                        begin
                            cnt_r <= 5'h00;
                            // Instruction then address, sixteen bits in all
                            if (hdr_nxt[`SHRP_DIR_POS] == `SHRP_DIR_READ)
                            begin
                                state_r <= SHRP_RDATA;
                            end
                            else
                            begin
                                state_r <= SHRP_WDATA;
                            end
                        end
                    end
                end
                SHRP_WDATA:
                begin
                    if (sclk_rise)
                    begin
                        wdata_r <= wdata_nxt;
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == `SHRP_DATA_LAST)
                        begin
                            state_r <= SHRP_DONE;
                        end
                    end
                end
                SHRP_RDATA:
                begin
                    state_r <= SHRP_RDATA;
                end
                SHRP_DONE:
                begin
                    // Extra clocks after the data byte are ignored
                    state_r <= SHRP_DONE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register access strobes
    // ----------------------------------------------------------------
    logic wr_go;
    logic rd_go;

    assign wr_go = ~sel_n_f & (state_r == SHRP_WDATA) & sclk_rise
        & (cnt_r == `SHRP_DATA_LAST);
    assign rd_go = ~sel_n_f & (state_r == SHRP_HDR) & sclk_rise
        & (cnt_r == `SHRP_HDR_LAST) & (hdr_nxt[`SHRP_DIR_POS] == `SHRP_DIR_READ);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reg_wr_en <= 1'b0;
            reg_rd_en <= 1'b0;
            reg_req <= '0;
        end
        else
        begin
            reg_wr_en <= wr_go;
            reg_rd_en <= rd_go;
            if (rd_go)
            begin
                reg_req.wr <= 1'b0;
                reg_req.instr_low <= hdr_nxt[14:11];
                reg_req.addr <= hdr_nxt[10:0];
                reg_req.data <= 8'h00;
            end
            else if (wr_go)
            begin
                reg_req.wr <= 1'b1;
                reg_req.instr_low <= hdr_r[14:11];
                reg_req.addr <= hdr_r[10:0];
                reg_req.data <= wdata_nxt;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data shifter
    // ----------------------------------------------------------------
    // The register file answers one cycle after the read strobe; the
    // host's first falling edge comes tens of cycles later, so the
    // load always wins the race.
    logic [`SHRP_DATA_BITS-1:0] rshift_r;
    logic sdo_r;
    logic rd_load_r;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rd_load_r <= 1'b0;
        end
        else
        begin
            rd_load_r <= reg_rd_en;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rshift_r <= 8'h00;
            sdo_r <= 1'b0;
        end
        else if (sel_n_nxt)
        begin
            sdo_r <= 1'b0;
        end
        else if (rd_load_r)
        begin
            rshift_r <= reg_rd_data;
        end
        else if ((state_r == SHRP_RDATA) && sclk_fall)
        begin
            sdo_r <= rshift_r[`SHRP_DATA_BITS-1];
            rshift_r <= {rshift_r[`SHRP_DATA_BITS-2:0], 1'b0};
        end
    end

    assign host_serial_out = sdo_r;
    // Enable is low while driving; released whenever select is high
    assign host_serial_out_oe_n = sel_n_f;

endmodule // shrp_serial_port

`default_nettype wire

// ---- testbench/shrp_serial_port_props.sv ----
// Checker for the serial host register port
`timescale 1ns/100ps
`default_nettype none
`include "shrp_consts.svh"
// ------------------------------
// Port checker
// ------------------------------
module shrp_serial_port_chk
    import shrp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic host_sel_n,
    input wire logic host_sclk,
    input wire logic host_serial_in,
    input wire logic host_serial_out,
    input wire logic host_serial_out_oe_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire shrp_req_t reg_req,
    input wire logic [`SHRP_DATA_BITS-1:0] reg_rd_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    chk_oe_release: assert property (host_sel_n [*8] |-> host_serial_out_oe_n)
        else $error("output enabled while select high");
    chk_idle_zero: assert property (host_serial_out_oe_n |-> !host_serial_out)
        else $error("output not zero while released");
    chk_strobe_excl: assert property (!(reg_wr_en && reg_rd_en))
        else $error("read and write strobes together");
    chk_wr_pulse: assert property (reg_wr_en |=> !reg_wr_en)
        else $error("write strobe longer than one cycle");
    chk_rd_pulse: assert property (reg_rd_en |=> !reg_rd_en)
        else $error("read strobe longer than one cycle");
    chk_req_dir: assert property ((reg_wr_en || reg_rd_en) |-> reg_req.wr == reg_wr_en)
        else $error("direction does not match strobe");
    chk_strobe_framed: assert property ((reg_wr_en || reg_rd_en)
        |-> !host_serial_out_oe_n && $past(!host_sel_n, 4))
        else $error("strobe outside a frame");
    chk_out_on_fall: assert property ($changed(host_serial_out) && !host_serial_out_oe_n
        |-> !host_sclk && $past(host_sclk, 8))
        else $error("output moved away from a clock fall");
    cover property (reg_wr_en);
    cover property (reg_rd_en);
    cover property ($fell(host_serial_out_oe_n));
endmodule // shrp_serial_port_chk

bind shrp_serial_port shrp_serial_port_chk shrp_serial_port_chk_i (.clk(clk), .reset(reset),
    .host_sel_n(host_sel_n), .host_sclk(host_sclk), .host_serial_in(host_serial_in),
    .host_serial_out(host_serial_out), .host_serial_out_oe_n(host_serial_out_oe_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_req(reg_req), .reg_rd_data(reg_rd_data));
`default_nettype wire

// ---- testbench/shrp_host_model.sv ----
// Behavioural host mastering the serial register port
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Host model
// ------------------------------
module shrp_host_model (
    input wire logic clk,
    input wire logic host_serial_out,
    output logic host_sel_n,
    output logic host_sclk,
    output logic host_serial_in
);
    initial
    begin
        host_sel_n = 1'b1;
        host_sclk = 1'b0;
        host_serial_in = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Serial clock idles low; fewer than 24 bits cuts the frame short
    task automatic frame(input logic [23:0] bits, input int nbits, output logic [7:0] rdat);
        rdat = 8'h00;
        tick(1);
        host_sel_n = 1'b0;
        for (int i = 23; i > 23 - nbits; i--)
        begin
            tick(4);
            host_serial_in = bits[i];
            tick(12);
            if (i < 8)
                rdat = {rdat[6:0], host_serial_out};
            host_sclk = 1'b1;
            tick(16);
            host_sclk = 1'b0;
        end
        tick(16);
        host_sel_n = 1'b1;
        // Released line shows the inverse so a stale value cannot pass
        host_serial_in = ~host_serial_in;
        tick(32);
    endtask
endmodule // shrp_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the serial host register port
`timescale 1ns/100ps
`default_nettype none
`include "shrp_consts.svh"
// ------------------------------
// Bench top
// ------------------------------
module tb;
    import shrp_pkg::*;
    logic clk, reset, host_sel_n, host_sclk, host_serial_in, host_serial_out;
    logic host_serial_out_oe_n, reg_wr_en, reg_rd_en;
    logic [`SHRP_DATA_BITS-1:0] reg_rd_data;
    shrp_req_t reg_req, last_req;
    logic [7:0] rdat;
    logic [7:0] rd_word = 8'h00;
    int error_cnt = 0, checks_done = 0, wr_cnt = 0, rd_cnt = 0, n0;
    shrp_serial_port shrp_serial_port_i (.clk(clk), .reset(reset), .host_sel_n(host_sel_n),
        .host_sclk(host_sclk), .host_serial_in(host_serial_in), .host_serial_out(host_serial_out),
        .host_serial_out_oe_n(host_serial_out_oe_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_req(reg_req), .reg_rd_data(reg_rd_data));
    shrp_host_model shrp_host_model_i (.clk(clk), .host_serial_out(host_serial_out),
        .host_sel_n(host_sel_n), .host_sclk(host_sclk), .host_serial_in(host_serial_in));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (reg_wr_en || reg_rd_en)
            last_req = reg_req;
        wr_cnt += int'(reg_wr_en === 1'b1);
        rd_cnt += int'(reg_rd_en === 1'b1);
        // Register file answers in the cycle after the read strobe
        reg_rd_data <= (reg_rd_en === 1'b1) ? rd_word : 8'h00;
    end
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_write;
        n0 = wr_cnt;
        shrp_host_model_i.frame({1'b0, 4'hA, 11'h7FF, 8'hC3}, 24, rdat);
        cmp(24'(wr_cnt - n0), 24'h1);
        cmp(last_req, {1'b1, 4'hA, 11'h7FF, 8'hC3});
        $display("test_write done");
    endtask
    task automatic test_read;
        n0 = rd_cnt;
        rd_word = 8'h96;
        shrp_host_model_i.frame({1'b1, 4'h3, 11'h000, 8'h00}, 24, rdat);
        cmp(24'(rd_cnt - n0), 24'h1);
        cmp(24'(last_req[23:8]), 24'({1'b0, 4'h3, 11'h000}));
        cmp(24'(rdat), 24'h96);
        cmp(24'(host_serial_out_oe_n), 24'h1);
        // Cut inside the data phase while a one stands on the line
        rd_word = 8'hFF;
        shrp_host_model_i.frame({1'b1, 4'h6, 11'h4C1, 8'h00}, 20, rdat);
        cmp(24'(rd_cnt - n0), 24'h2);
        cmp(24'(last_req[23:8]), 24'({1'b0, 4'h6, 11'h4C1}));
        cmp(24'(rdat), 24'h0F);
        cmp(24'(host_serial_out), 24'h0);
        $display("test_read done");
    endtask
    task automatic test_abort;
        n0 = wr_cnt + rd_cnt;
        shrp_host_model_i.frame({1'b0, 4'h1, 11'h155, 8'h5A}, 20, rdat);
        shrp_host_model_i.frame({1'b1, 4'h1, 11'h2AA, 8'h00}, 12, rdat);
        cmp(24'(wr_cnt + rd_cnt - n0), 24'h0);
        shrp_host_model_i.frame({1'b0, 4'h5, 11'h001, 8'h81}, 24, rdat);
        cmp(last_req, {1'b1, 4'h5, 11'h001, 8'h81});
        $display("test_abort done");
    endtask
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        reset = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        reset = 1'b0;
        test_write();
        test_read();
        test_abort();
        give_verdict();
    end
    // Six frames need about 21 us; the limit leaves wide margin
    initial
    begin
        #100000;
        error_cnt++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
